// ==== core/lcr_pkg.sv ====
// Purpose: Shared constants and types for the lane control register bank
// Assumes: Byte addressing on the register bus, one 32-bit word per register
// Notes: Lane control field layout matches the register bit layout exactly
package lcr_pkg;

    // Register map (byte offsets)
    localparam int LCR_ADDR_W = 8;
    localparam int LCR_NUM_LANES = 2;
    localparam int LCR_FIRST_LANE = 4;
    localparam logic [7:0] LCR_LANE_OFFSET [LCR_NUM_LANES] = '{8'h14, 8'h18};

    // Field positions inside a lane control word
    localparam int LCR_SPARE_MSB = 9;
    localparam int LCR_SPARE_LSB = 2;
    localparam int LCR_POWER_OFF_BIT = 1;
    localparam int LCR_TX_INVERT_BIT = 0;
    localparam int LCR_CTRL_W = 10;

    // Width of the lane power-off vector seen by the transport layer
    localparam int LCR_LANE_VEC_W = 8;

    // One lane's stored control; bit order equals register bits 9:0
    typedef struct packed {
        logic [7:0] spare;
        logic power_off;
        logic tx_invert;
    } lcr_ctrl_s;

    // Values after reset
    localparam lcr_ctrl_s LCR_CTRL_RESET = '{spare: 8'h00, power_off: 1'b0, tx_invert: 1'b0};
    localparam logic [31:0] LCR_READ_RESET = 32'h0000_0000;

endpackage

// ==== core/lcr_lane_reg.sv ====
// Purpose: One lane control register with byte-lane write merge
// Assumes: Write strobe already qualified by address match and bus accept
// Notes: Only bits 9:0 are stored; upper bits never exist in hardware
`timescale 1ns/1ps
`default_nettype none
module lcr_lane_reg
    import lcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [3:0] byte_en,
    input wire logic [31:0] wr_data,
    output lcr_ctrl_s ctrl
);

    lcr_ctrl_s ctrl_q;
    logic [LCR_CTRL_W-1:0] ctrl_d;
    wire logic [LCR_CTRL_W-1:0] cur = ctrl_q;

    // Byte 0 carries bits 7:0, byte 1 carries bits 9:8 of the spare field
    assign ctrl_d[7:0] = (wr_en && byte_en[0]) ? wr_data[7:0] : cur[7:0];
    assign ctrl_d[9:8] = (wr_en && byte_en[1]) ? wr_data[9:8] : cur[9:8];

    // Storage; bits 31:10 are simply not kept
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_q <= LCR_CTRL_RESET;
        end else begin
            ctrl_q <= lcr_ctrl_s'(ctrl_d);
        end
    end

    assign ctrl = ctrl_q;

endmodule // lcr_lane_reg
`default_nettype wire

// ==== core/lcr_top.sv ====
// Purpose: Lane control register bank for lanes 4 and 5 with power-off and polarity outputs
// Assumes: Avalon-MM master on REF_CLK; transmit data arrives on the same clock
// Notes: Every access waits exactly one cycle; unmapped reads return zero
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: Bits 9:2 spare, read-write, reset zero
// R2: Bit 1 power-down, read-write, reset zero
// R3: Stored power-down drives power-off vector element n
// R4: Transport layer marks powered-down lane dropped
// R5: Outside logic may mask transceiver receive resets
// R6: Bit 0 inverts transmit data polarity
// R7: Lane 4 register decoded at offset 0x14
// R8: Bits 31:10 read zero, writes ignored
module lcr_top
    import lcr_pkg::*;
#(
    parameter int TX_W = 32
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [LCR_ADDR_W-1:0] AV_ADDRESS,
    input wire logic AV_READ,
    input wire logic AV_WRITE,
    input wire logic [31:0] AV_WRITEDATA,
    input wire logic [3:0] AV_BYTEENABLE,
    output logic [31:0] AV_READDATA,
    output logic AV_WAITREQUEST,
    input wire logic [LCR_NUM_LANES*TX_W-1:0] TX_DATA_IN,
    output logic [LCR_NUM_LANES*TX_W-1:0] TX_DATA_OUT,
    output logic [LCR_LANE_VEC_W-1:0] LANE_POWER_OFF,
    output logic [LCR_LANE_VEC_W-1:0] TL_LANE_DROPPED
);

    logic ack_q;
    logic [31:0] rdata_q;
    logic [LCR_NUM_LANES*TX_W-1:0] tx_q;
    lcr_ctrl_s lane_ctrl [LCR_NUM_LANES];
    logic [LCR_NUM_LANES-1:0] lane_sel;
    logic [LCR_CTRL_W-1:0] rd_chain [LCR_NUM_LANES+1];

    // Bus request decode; one wait cycle lets read data come from a flop
    wire logic av_req = AV_READ || AV_WRITE;
    wire logic av_accept = av_req && ack_q;
    wire logic wr_accept = AV_WRITE && ack_q;
    wire logic rd_capture = AV_READ && !ack_q;

    assign AV_WAITREQUEST = av_req && !ack_q;
    assign AV_READDATA = rdata_q;

    // Acknowledge toggles so back-to-back requests each see one wait cycle
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= av_req && !ack_q;
        end
    end

    // Per-lane address match, register and transmit path
    assign rd_chain[0] = '0;
    generate
        for (genvar i = 0; i < LCR_NUM_LANES; i++) begin : g_lane
            wire logic [TX_W-1:0] tx_in = TX_DATA_IN[i*TX_W +: TX_W];
            wire logic [TX_W-1:0] tx_inv = tx_in ^ {TX_W{lane_ctrl[i].tx_invert}}; // R6
            wire logic [TX_W-1:0] tx_d = lane_ctrl[i].power_off ? '0 : tx_inv; // R4

            // Word match only; low address bits do not select a lane
            assign lane_sel[i] = (AV_ADDRESS[LCR_ADDR_W-1:2] == LCR_LANE_OFFSET[i][LCR_ADDR_W-1:2]); // R7

            lcr_lane_reg u_reg (
                .ref_clk(REF_CLK),
                .rstn(RSTN),
                .wr_en(wr_accept && lane_sel[i]), // R1 R2 R6 R8
                .byte_en(AV_BYTEENABLE),
                .wr_data(AV_WRITEDATA),
                .ctrl(lane_ctrl[i])
            );

            // Read mux as an OR chain of selected lanes
            assign rd_chain[i+1] = rd_chain[i] | (lane_sel[i] ? LCR_CTRL_W'(lane_ctrl[i]) : '0);

            // Registered transmit data, one cycle of latency per lane
            always_ff @(posedge REF_CLK) begin
                if (!RSTN) begin
                    tx_q[i*TX_W +: TX_W] <= '0;
                end else begin
                    tx_q[i*TX_W +: TX_W] <= tx_d;
                end
            end
        end
    endgenerate

    assign TX_DATA_OUT = tx_q;

    // Power-off vector: only elements of lanes held here are driven high
    generate
        for (genvar b = 0; b < LCR_LANE_VEC_W; b++) begin : g_vec
            if (b >= LCR_FIRST_LANE && b < LCR_FIRST_LANE + LCR_NUM_LANES) begin : g_own
                assign LANE_POWER_OFF[b] = lane_ctrl[b-LCR_FIRST_LANE].power_off; // R3
                assign TL_LANE_DROPPED[b] = lane_ctrl[b-LCR_FIRST_LANE].power_off; // R4
            end else begin : g_other
                assign LANE_POWER_OFF[b] = 1'b0;
                assign TL_LANE_DROPPED[b] = 1'b0;
            end
        end
    endgenerate

    // Read data captured in the wait cycle; upper bits always zero
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            rdata_q <= LCR_READ_RESET;
        end else if (rd_capture) begin
            rdata_q <= {22'h000000, rd_chain[LCR_NUM_LANES]}; // R8
        end
    end

    // Checks; all in the one clock domain
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);

    wire logic [LCR_CTRL_W-1:0] l4_bits = lane_ctrl[0];
    wire logic [LCR_CTRL_W-1:0] l5_bits = lane_ctrl[1];
    wire logic any_sel = |lane_sel;
    wire logic l4_full_wr = wr_accept && AV_ADDRESS == LCR_LANE_OFFSET[0] && AV_BYTEENABLE == 4'hf;
    wire logic l5_full_wr = wr_accept && AV_ADDRESS == LCR_LANE_OFFSET[1] && AV_BYTEENABLE == 4'hf;

    AST_WAIT_ONE: assert property ((av_req && AV_WAITREQUEST) |=> (!av_req || !AV_WAITREQUEST))
        else $error("request not answered after one wait cycle");

    AST_L4_WRITE: assert property (l4_full_wr |=> l4_bits == $past(AV_WRITEDATA[9:0])) // R7
        else $error("lane 4 write at 0x14 not stored");

    AST_L5_WRITE: assert property (l5_full_wr |=> l5_bits == $past(AV_WRITEDATA[9:0])) // R1
        else $error("lane 5 write not stored");

    AST_UPPER_ZERO: assert property ((AV_READ && !AV_WAITREQUEST) |-> AV_READDATA[31:10] == 22'h000000) // R8
        else $error("reserved read bits not zero");

    AST_L4_READBACK: assert property ((AV_READ && !AV_WAITREQUEST && AV_ADDRESS == LCR_LANE_OFFSET[0])
        |-> AV_READDATA[9:0] == l4_bits) // R2
        else $error("lane 4 read data does not match stored value");

    AST_UNMAPPED: assert property ((av_accept && !any_sel) |=> ($stable(l4_bits) && $stable(l5_bits)
        && (!$past(AV_READ) || $past(AV_READDATA) == 32'h0000_0000)))
        else $error("unmapped access changed state or read nonzero");

    AST_POWER_VEC: assert property (LANE_POWER_OFF == {2'b00, lane_ctrl[1].power_off, lane_ctrl[0].power_off, 4'h0}) // R3
        else $error("power-off vector mismatch");

    AST_TX_INVERT: assert property ((!lane_ctrl[0].power_off && lane_ctrl[0].tx_invert)
        |=> TX_DATA_OUT[TX_W-1:0] == ~$past(TX_DATA_IN[TX_W-1:0])) // R6
        else $error("lane 4 transmit data not inverted");

    AST_TX_PASS: assert property ((!lane_ctrl[1].power_off && !lane_ctrl[1].tx_invert)
        |=> TX_DATA_OUT[2*TX_W-1:TX_W] == $past(TX_DATA_IN[2*TX_W-1:TX_W])) // R6
        else $error("lane 5 transmit data altered");

    AST_DROPPED: assert property (lane_ctrl[1].power_off |=> (TX_DATA_OUT[2*TX_W-1:TX_W] == '0
        && TL_LANE_DROPPED[5] == lane_ctrl[1].power_off || $fell(lane_ctrl[1].power_off))) // R4
        else $error("dropped lane 5 still transmitting");

    AST_RESET_ZERO: assert property ($past(!RSTN) |-> (l4_bits == LCR_CTRL_RESET && l5_bits == LCR_CTRL_RESET)) // R1
        else $error("lane registers not zero after reset");

    // Byte 1 disabled: the top two spare bits of lane 4 must not move
    AST_L4_HIGH_KEEP: assert property ((wr_accept && lane_sel[0] && !AV_BYTEENABLE[1])
        |=> l4_bits[9:8] == $past(l4_bits[9:8])) // R1
        else $error("lane 4 bits 9:8 written without their byte enable");

    // Byte 0 disabled: power-off, invert and low spare bits of lane 5 stay
    AST_L5_LOW_KEEP: assert property ((wr_accept && lane_sel[1] && !AV_BYTEENABLE[0])
        |=> l5_bits[7:0] == $past(l5_bits[7:0])) // R2
        else $error("lane 5 bits 7:0 written without their byte enable");

    // No accepted write means no register may change
    AST_NO_WRITE_HOLD: assert property (!wr_accept
        |=> ($stable(l4_bits) && $stable(l5_bits))) // R1
        else $error("lane register changed without an accepted write");

    // Lane 5 read-back at its chosen word
    AST_L5_READBACK: assert property ((AV_READ && !AV_WAITREQUEST && AV_ADDRESS == LCR_LANE_OFFSET[1])
        |-> AV_READDATA[9:0] == l5_bits) // R2
        else $error("lane 5 read data does not match stored value");

    // Drop mark to the transport layer mirrors the power-off vector
    AST_DROP_MIRROR: assert property (TL_LANE_DROPPED == LANE_POWER_OFF) // R4
        else $error("drop mark differs from power-off vector");

    // Lane 4 powered off: its transmit word must be zero next cycle
    AST_DROPPED_L4: assert property (lane_ctrl[0].power_off
        |=> TX_DATA_OUT[TX_W-1:0] == '0) // R4
        else $error("dropped lane 4 still transmitting");

    // Lane 4 without invert passes data straight through
    AST_TX_PASS_L4: assert property ((!lane_ctrl[0].power_off && !lane_ctrl[0].tx_invert)
        |=> TX_DATA_OUT[TX_W-1:0] == $past(TX_DATA_IN[TX_W-1:0])) // R6
        else $error("lane 4 transmit data altered");

    // Lane 5 with invert flips every bit of its word
    AST_TX_INVERT_L5: assert property ((!lane_ctrl[1].power_off && lane_ctrl[1].tx_invert)
        |=> TX_DATA_OUT[2*TX_W-1:TX_W] == ~$past(TX_DATA_IN[2*TX_W-1:TX_W])) // R6
        else $error("lane 5 transmit data not inverted");

    // Outputs are quiet right after reset, so nothing stale reaches the link
    AST_RESET_OUT: assert property ($past(!RSTN)
        |-> (TX_DATA_OUT == '0 && AV_READDATA == LCR_READ_RESET)) // R1
        else $error("outputs not zero after reset");

    // Main scenarios
    COV_L4_POWER: cover property (l4_full_wr ##1 lane_ctrl[0].power_off);
    // Partial write that leaves the upper spare bits alone
    COV_L4_PARTIAL: cover property (wr_accept && lane_sel[0] && AV_BYTEENABLE[0] && !AV_BYTEENABLE[1]);
    COV_L5_INVERT: cover property (l5_full_wr ##1 lane_ctrl[1].tx_invert);
    COV_READ_L5: cover property (AV_READ && !AV_WAITREQUEST && AV_ADDRESS == LCR_LANE_OFFSET[1]);
    COV_UNMAPPED: cover property (av_accept && !any_sel);

endmodule // lcr_top
`default_nettype wire

// ==== verif/lcr_top_bench.sv ====
// Purpose: Self-checking bench for the lane control register bank
// Assumes: Avalon-MM slave answers within a few cycles; lane 5 word at package offset
// Notes: Random data from a fixed seed, plus full-word and unmapped corners
`timescale 1ns/1ps
`default_nettype none
module lcr_top_bench
    import lcr_pkg::*;
();
    logic REF_CLK, RSTN, AV_READ, AV_WRITE, AV_WAITREQUEST;
    logic [7:0] AV_ADDRESS, LANE_POWER_OFF, TL_LANE_DROPPED;
    logic [31:0] AV_WRITEDATA, AV_READDATA, rd;
    logic [3:0] AV_BYTEENABLE;
    logic [63:0] TX_DATA_IN, TX_DATA_OUT, tx_v;
    logic [9:0] mdl [2];
    logic [7:0] offs [3];
    int error_cnt, samples_checked;

    lcr_top #(.TX_W(32)) dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .AV_ADDRESS(AV_ADDRESS), .AV_READ(AV_READ),
        .AV_WRITE(AV_WRITE), .AV_WRITEDATA(AV_WRITEDATA), .AV_BYTEENABLE(AV_BYTEENABLE),
        .AV_READDATA(AV_READDATA), .AV_WAITREQUEST(AV_WAITREQUEST), .TX_DATA_IN(TX_DATA_IN),
        .TX_DATA_OUT(TX_DATA_OUT), .LANE_POWER_OFF(LANE_POWER_OFF), .TL_LANE_DROPPED(TL_LANE_DROPPED));

    // Expected read word: only bits 9:0 of a mapped lane ever show
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        for (int i = 0; i < 2; i++) begin
            if (a[7:2] == offs[i][7:2]) begin
                return {22'h0, mdl[i]};
            end
        end
        return 32'h0;
    endfunction

    // Expected transmit word: powered-off lane is zero, else optional inversion
    function automatic logic [63:0] exp_tx(input logic [63:0] x);
        logic [63:0] r;
        for (int i = 0; i < 2; i++) begin
            r[i*32 +: 32] = mdl[i][1] ? 32'h0 : (mdl[i][0] ? ~x[i*32 +: 32] : x[i*32 +: 32]);
        end
        return r;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One bus cycle; an idle edge first so a strobe is never set twice in one step
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge REF_CLK);
        AV_WRITE <= wr;
        AV_READ <= !wr;
        AV_ADDRESS <= a;
        AV_WRITEDATA <= d;
        AV_BYTEENABLE <= be;
        @(negedge REF_CLK);
        while (AV_WAITREQUEST !== 1'b0) begin
            n++;
            if (n > 20) begin
                error_cnt++;
                $display("unexpected at %0t: bus wait ran out", $time);
                give_verdict();
            end
            @(negedge REF_CLK);
        end
        @(posedge REF_CLK);
        rd = AV_READDATA;
        AV_WRITE <= 1'b0;
        AV_READ <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            if (wr && a[7:2] == offs[i][7:2]) begin
                if (be[0]) mdl[i][7:0] = d[7:0];
                if (be[1]) mdl[i][9:8] = d[9:8];
            end
        end
    endtask

    // Write, look at the power-off vectors and data path, then read back
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        bus(1'b1, a, d, be);
        @(negedge REF_CLK);
        check({56'h0, LANE_POWER_OFF}, {58'h0, mdl[1][1], mdl[0][1], 4'h0});
        check({56'h0, TL_LANE_DROPPED}, {58'h0, mdl[1][1], mdl[0][1], 4'h0});
        repeat (3) begin
            @(posedge REF_CLK);
            tx_v = {$urandom, $urandom};
            TX_DATA_IN <= tx_v;
            @(posedge REF_CLK);
            @(negedge REF_CLK);
            check(TX_DATA_OUT, exp_tx(tx_v));
        end
        bus(1'b0, a, 32'h0, 4'h0);
        check({32'h0, rd}, {32'h0, exp_rd(a)});
    endtask

    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    initial begin
        RSTN = 1'b0;
        AV_READ = 1'b0;
        AV_WRITE = 1'b0;
        AV_ADDRESS = 8'h00;
        AV_WRITEDATA = 32'h0;
        AV_BYTEENABLE = 4'h0;
        TX_DATA_IN = 64'h0;
        mdl = '{default: 10'h0};
        offs = '{8'h14, LCR_LANE_OFFSET[1], 8'h00};
        error_cnt = 0;
        samples_checked = 0;
        void'($urandom(32'h136b));
        repeat (4) @(posedge REF_CLK);
        RSTN <= 1'b1;
        // Reset values of both lanes, then an unmapped word
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, offs[i], 32'h0, 4'h0);
            check({32'h0, rd}, 64'h0);
        end
        // Corners: all ones, upper bytes only, unmapped word
        wr_rd(8'h14, 32'hffff_ffff, 4'hf);
        wr_rd(offs[1], 32'hffff_ffff, 4'hc);
        wr_rd(8'h1c, 32'hffff_ffff, 4'hf);
        wr_rd(8'h17, 32'h0000_0002, 4'h1);
        for (int k = 0; k < 30; k++) begin
            offs[2] = 8'($urandom);
            wr_rd(offs[$urandom_range(0, 2)], $urandom, 4'($urandom));
        end
        give_verdict();
    end
endmodule // lcr_top_bench
`default_nettype wire
